// *** csg_defines.vh ***
// Constants for the clock source safeguard block.
`ifndef CSG_DEFINES_VH
`define CSG_DEFINES_VH

// Register map and field layout.
`define CSG_ADDR_W           8
`define CSG_CONV_CTRL_ADDR   8'hd1
`define CSG_CONV_CTRL_RESET  8'h40
`define CSG_OSC_OFF_BIT      2

// Internal clock dividers and reset delay.
`define CSG_PERIPH_DIV       12
`define CSG_CORE_DIV         13
`define CSG_POR_DELAY_TICKS  2048

// System clock period in nanoseconds.
`define CSG_CLK_PERIOD_NS    50

// Auxiliary oscillator period, a plain default figure.
`define CSG_AUX_PERIOD_NS    4000
`define CSG_AUX_PERIOD_CYC   ((`CSG_AUX_PERIOD_NS + `CSG_CLK_PERIOD_NS - 1) / `CSG_CLK_PERIOD_NS)

// Shortest internal period allowed by the safeguard at normal supply.
`define CSG_SG_MIN_NS        125
`define CSG_SG_MIN_CYC       ((`CSG_SG_MIN_NS + `CSG_CLK_PERIOD_NS - 1) / `CSG_CLK_PERIOD_NS)

// Shortest internal period allowed by the safeguard at low supply.
`define CSG_SG_LOW_NS        250
`define CSG_SG_LOW_CYC       ((`CSG_SG_LOW_NS + `CSG_CLK_PERIOD_NS - 1) / `CSG_CLK_PERIOD_NS)

// Longest gap between main edges before an edge counts as missing.
`define CSG_MISS_NS          1000
`define CSG_MISS_CYC         (`CSG_MISS_NS / `CSG_CLK_PERIOD_NS)

`endif

// *** csg_clock_source_safeguard.v ***
// Clock source selection, safeguard filter, dividers and reset delay.
//
// Contract
// RULE1 - Peripheral clock is internal clock over twelve.
// RULE2 - Core clock is internal clock over thirteen.
// RULE3 - Oscillator type comes from a factory option.
// RULE4 - Off bit stops main, starts auxiliary oscillator.
// RULE5 - Clearing bit or reset restarts main oscillator.
// RULE6 - Auxiliary oscillator exists only with safeguard.
// RULE7 - Auxiliary starts one period after missing edge.
// RULE8 - Core runs normally at auxiliary rate.
// RULE9 - Power-on delay counts auxiliary ticks until main.
// RULE10 - Auxiliary stops once main oscillator runs.
// RULE11 - Control bit two switches main oscillator off.
// RULE12 - Other control bits unused for clocking.
// RULE13 - Safeguard enabled by factory option only.
// RULE14 - Safeguard drops spikes and over-frequency cycles.
// RULE15 - Internal clock never exceeds safeguard maximum.
// RULE16 - Control register resets to documented value.
// RULE17 - Internal reset released after 2048 internal cycles.
// RULE18 - Source switching never truncates internal pulses.
// RULE19 - Reads return the current off bit.
`include "csg_defines.vh"

module csg_clock_source_safeguard #(
   parameter AUX_CYC   = `CSG_AUX_PERIOD_CYC,   // Auxiliary period in system cycles.
   parameter SG_MIN    = `CSG_SG_MIN_CYC,       // Safeguard minimum period, normal supply.
   parameter SG_LOW    = `CSG_SG_LOW_CYC,       // Safeguard minimum period, low supply.
   parameter MISS_CYC  = `CSG_MISS_CYC,         // Gap after which a main edge is missing.
   parameter POR_TICKS = `CSG_POR_DELAY_TICKS   // Internal ticks before reset release.
) (
   input  wire                   sys_clk_in,             // System clock, 20 MHz.
   input  wire                   reset_n_in,             // Synchronous reset, active low.
   input  wire                   osc_input_pin_in,       // Main oscillator waveform pin.
   input  wire                   resistor_clock_opt_in,  // Factory option: resistor network.
   input  wire                   osc_safeguard_opt_in,   // Factory option: safeguard fitted.
   input  wire                   supply_low_in,          // High when supply is reduced.
   input  wire [`CSG_ADDR_W-1:0] reg_addr_in,            // Register address.
   input  wire [7:0]             reg_wdata_in,           // Register write data.
   input  wire                   reg_wr_in,              // Write strobe.
   input  wire                   reg_rd_in,              // Read strobe.
   output reg  [7:0]             reg_rdata_out,          // Read data, one cycle later.
   output reg                    main_osc_en_out,        // Main oscillator enable.
   output reg                    resistor_clock_out,     // Oscillator configured for resistor.
   output reg                    aux_low_freq_osc_out,   // Auxiliary oscillator running.
   output reg                    main_running_out,       // Main oscillator edges present.
   output reg                    int_tick_out,           // Internal clock pulse.
   output reg                    periph_tick_out,        // Peripheral clock pulse.
   output reg                    core_tick_out,          // Core machine clock pulse.
   output reg                    int_reset_n_out         // Internal reset, active low.
);

   // Counter widths, fixed independently of the parameters.
   localparam GAP_W = 12;                 // Gap counters saturate far above any period.
   localparam POR_W = 13;                 // Holds the reset delay count.

   // Divider end points, sized to the divider counters.
   // Declaring them at counter width keeps every comparison and call exact.
   localparam [3:0] PERIPH_LAST = `CSG_PERIPH_DIV - 1;   // Last peripheral count. [RULE1]
   localparam [3:0] CORE_LAST   = `CSG_CORE_DIV - 1;     // Last core count. [RULE2]

   // Factory options captured while reset is held.
   reg              sg_opt_reg;           // Safeguard option latched at reset.
   reg              timing_resistor_opt_reg;         // Resistor network option latched at reset.

   // Control register contents.
   reg  [7:0]       conv_ctrl_reg;        // Converter and oscillator control.

   // Pin synchroniser and accepted level.
   reg              pin_s1_reg;           // First synchroniser stage.
   reg              pin_s2_reg;           // Second synchroniser stage.
   reg              pin_s3_reg;           // Third synchroniser stage.
   reg              pin_lvl_reg;          // Last accepted pin level.

   // Timing counters.
   reg  [GAP_W-1:0] miss_cnt_reg;         // Cycles since last main rising edge.
   reg  [GAP_W-1:0] gap_cnt_reg;          // Cycles since last internal tick.
   reg  [GAP_W-1:0] aux_cnt_reg;          // Auxiliary period counter.
   reg              sel_aux_reg;          // Internal clock taken from auxiliary.
   reg  [3:0]       periph_cnt_reg;       // Divide-by-twelve counter.
   reg  [3:0]       core_cnt_reg;         // Divide-by-thirteen counter.
   reg  [POR_W-1:0] por_cnt_reg;          // Reset delay counter.

   // Combinational terms.
   wire             main_rise;            // Accepted rising edge of the main pin.
   wire             main_missing;         // Main oscillator has gone quiet.
   wire [GAP_W-1:0] min_gap;              // Active safeguard minimum period.
   wire             gap_ok;               // A full minimum period has passed.
   wire             main_tick;            // Main edge that passes the safeguard.
   wire             aux_tick;             // Auxiliary oscillator period end.
   wire             int_tick;             // Internal clock pulse from selected source.
   wire             osc_off;              // Off request honoured by the option.

   // Wrapping counter step used by both dividers.
   function [3:0] csg_wrap;
      input [3:0] cnt;
      input [3:0] last;
      begin
         csg_wrap = (cnt == last) ? 4'h0 : cnt + 4'h1;
      end
   endfunction

   // A pin change counts only once the second and third stages agree.
   assign main_rise = pin_s2_reg & pin_s3_reg & ~pin_lvl_reg;

   // The edge is missing once the gap reaches the timeout.
   assign main_missing = (miss_cnt_reg >= MISS_CYC[GAP_W-1:0]);

   // Lower supply demands a longer period, so a lower maximum rate.
   assign min_gap = supply_low_in ? SG_LOW[GAP_W-1:0] : SG_MIN[GAP_W-1:0];   // [RULE15]

   // Spikes and over-frequency edges arriving too soon are dropped.
   assign gap_ok = (gap_cnt_reg >= min_gap);                                 // [RULE14]

   // Without the safeguard every main edge passes unfiltered.
   assign main_tick = main_rise & (~sg_opt_reg | gap_ok);                    // [RULE13]

   // The auxiliary period ends only while it is selected.
   assign aux_tick = sel_aux_reg & (aux_cnt_reg == AUX_CYC[GAP_W-1:0] - 1'b1);

   // Exactly one source feeds the internal clock at any time.
   assign int_tick = sel_aux_reg ? aux_tick : main_tick;                     // [RULE8]

   // The off bit only has effect when the safeguard is fitted.
   assign osc_off = sg_opt_reg & conv_ctrl_reg[`CSG_OSC_OFF_BIT];            // [RULE4]

   // Options behave as straps: sampled only while reset is held.
   always @(posedge sys_clk_in) begin
      if (!reset_n_in) begin
         sg_opt_reg   <= osc_safeguard_opt_in;                               // [RULE13]
         timing_resistor_opt_reg <= resistor_clock_opt_in;                              // [RULE3]
      end
   end

   // Control register write and read port.
   always @(posedge sys_clk_in) begin
      if (!reset_n_in) begin
         // Reset leaves the main oscillator running.
         conv_ctrl_reg <= `CSG_CONV_CTRL_RESET;                              // [RULE16] [RULE5]
         reg_rdata_out <= 8'h00;
      end else begin
         if (reg_wr_in && reg_addr_in == `CSG_CONV_CTRL_ADDR) begin
            // Upper and lower bits are kept for the converter only.
            conv_ctrl_reg <= reg_wdata_in;                                   // [RULE11] [RULE12]
         end
         if (reg_rd_in && reg_addr_in == `CSG_CONV_CTRL_ADDR) begin
            reg_rdata_out <= conv_ctrl_reg;                                  // [RULE19]
         end else if (reg_rd_in) begin
            // Unmapped addresses read as zero.
            reg_rdata_out <= 8'h00;
         end else begin
            // Read data stands for one cycle only.
            reg_rdata_out <= 8'h00;
         end
      end
   end

   // Three-stage synchroniser on the oscillator pin.
   always @(posedge sys_clk_in) begin
      if (!reset_n_in) begin
         pin_s1_reg  <= 1'b0;
         pin_s2_reg  <= 1'b0;
         pin_s3_reg  <= 1'b0;
         pin_lvl_reg <= 1'b0;
      end else begin
         pin_s1_reg <= osc_input_pin_in;
         pin_s2_reg <= pin_s1_reg;
         pin_s3_reg <= pin_s2_reg;
         // The accepted level only moves when both late stages agree.
         if (pin_s2_reg == pin_s3_reg) begin
            pin_lvl_reg <= pin_s3_reg;
         end
      end
   end

   // Missing-edge timer and internal-period gap counter.
   always @(posedge sys_clk_in) begin
      if (!reset_n_in) begin
         miss_cnt_reg <= {GAP_W{1'b1}};
         gap_cnt_reg  <= {GAP_W{1'b1}};
      end else begin
         // Any raw rising edge proves the main oscillator alive.
         if (main_rise) begin
            miss_cnt_reg <= {GAP_W{1'b0}};
         end else if (!main_missing) begin
            miss_cnt_reg <= miss_cnt_reg + 1'b1;
         end
         // The gap restarts on every delivered internal pulse.
         if (int_tick) begin
            gap_cnt_reg <= {GAP_W{1'b0}};
         end else if (gap_cnt_reg != {GAP_W{1'b1}}) begin
            gap_cnt_reg <= gap_cnt_reg + 1'b1;
         end
      end
   end

   // Source selection and auxiliary oscillator.
   // Switching waits for a full minimum period since the last pulse,
   // so neither source can leave a shortened internal cycle behind.
   always @(posedge sys_clk_in) begin
      if (!reset_n_in) begin
         sel_aux_reg <= 1'b0;
         aux_cnt_reg <= {GAP_W{1'b0}};
      end else begin
         if (!sg_opt_reg) begin
            // No safeguard means no auxiliary oscillator at all.
            sel_aux_reg <= 1'b0;                                             // [RULE6]
         end else if (!sel_aux_reg && main_missing && gap_ok) begin
            // Counter restart gives one auxiliary period before the first tick.
            sel_aux_reg <= 1'b1;                                             // [RULE7] [RULE18]
         end else if (sel_aux_reg && !main_missing && gap_ok && !osc_off) begin
            // Main edges are back, so the auxiliary stops.
            sel_aux_reg <= 1'b0;                                             // [RULE10] [RULE18]
         end
         if (!sel_aux_reg || aux_tick) begin
            aux_cnt_reg <= {GAP_W{1'b0}};
         end else begin
            aux_cnt_reg <= aux_cnt_reg + 1'b1;
         end
      end
   end

   // Oscillator control outputs.
   always @(posedge sys_clk_in) begin
      if (!reset_n_in) begin
         main_osc_en_out      <= 1'b1;                                       // [RULE5]
         resistor_clock_out   <= 1'b0;
         aux_low_freq_osc_out <= 1'b0;
         main_running_out     <= 1'b0;
      end else begin
         // Clearing the off bit re-enables the main oscillator one cycle after the register update.
         main_osc_en_out      <= ~osc_off;                                   // [RULE4] [RULE5]
         resistor_clock_out   <= timing_resistor_opt_reg;                               // [RULE3]
         aux_low_freq_osc_out <= sel_aux_reg;
         main_running_out     <= ~main_missing;
      end
   end

   // Internal clock dividers for peripherals and core.
   always @(posedge sys_clk_in) begin
      if (!reset_n_in) begin
         periph_cnt_reg  <= 4'h0;
         core_cnt_reg    <= 4'h0;
         int_tick_out    <= 1'b0;
         periph_tick_out <= 1'b0;
         core_tick_out   <= 1'b0;
      end else begin
         int_tick_out    <= int_tick;
         periph_tick_out <= 1'b0;
         core_tick_out   <= 1'b0;
         if (int_tick) begin
            periph_cnt_reg  <= csg_wrap(periph_cnt_reg, PERIPH_LAST);         // [RULE1]
            core_cnt_reg    <= csg_wrap(core_cnt_reg, CORE_LAST);             // [RULE2]
            periph_tick_out <= (periph_cnt_reg == PERIPH_LAST);               // [RULE1]
            core_tick_out   <= (core_cnt_reg == CORE_LAST);                   // [RULE2]
         end
      end
   end

   // Internal reset delay counted in internal clock pulses.
   // With the safeguard fitted, these pulses come from the auxiliary until the main oscillator runs.
   always @(posedge sys_clk_in) begin
      if (!reset_n_in) begin
         por_cnt_reg     <= {POR_W{1'b0}};
         int_reset_n_out <= 1'b0;
      end else if (int_tick && por_cnt_reg != POR_TICKS[POR_W-1:0]) begin
         por_cnt_reg <= por_cnt_reg + 1'b1;                                  // [RULE9]
         if (por_cnt_reg == POR_TICKS[POR_W-1:0] - 1'b1) begin
            int_reset_n_out <= 1'b1;                                         // [RULE17]
         end
      end
   end

endmodule // csg_clock_source_safeguard

// *** csg_clock_source_safeguard_chk.sv ***
// Assertion checker for the clock source safeguard block.
`include "csg_defines.vh"
module csg_chk (
   input wire                   sys_clk_in,           // System clock.
   input wire                   reset_n_in,           // Synchronous reset, active low.
   input wire                   osc_safeguard_opt_in, // Safeguard strap.
   input wire                   supply_low_in,        // Reduced supply flag.
   input wire [`CSG_ADDR_W-1:0] reg_addr_in,          // Register address.
   input wire [7:0]             reg_wdata_in,         // Register write data.
   input wire                   reg_wr_in,            // Write strobe.
   input wire                   reg_rd_in,            // Read strobe.
   input wire [7:0]             reg_rdata_out,        // Read data.
   input wire                   main_osc_en_out,      // Main oscillator enable.
   input wire                   aux_low_freq_osc_out, // Auxiliary oscillator selected.
   input wire                   main_running_out,     // Main edges present.
   input wire                   int_tick_out,         // Internal clock pulse.
   input wire                   int_reset_n_out       // Internal reset, active low.
);
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!reset_n_in);
   // A write followed at once by a read of the same control register.
   sequence s_wr_rd;
      reg_wr_in && reg_addr_in == 8'hd1 ##1 reg_rd_in && reg_addr_in == 8'hd1;
   endsequence
   property p_readback; s_wr_rd |=> reg_rdata_out == $past(reg_wdata_in, 2); endproperty
   a_readback: assert property (p_readback) else $error("read back differs from write");
   property p_idle; !reg_rd_in |=> reg_rdata_out == 8'h00; endproperty
   a_idle: assert property (p_idle) else $error("read data not cleared");
   property p_unmapped; reg_rd_in && reg_addr_in != 8'hd1 |=> reg_rdata_out == 8'h00; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   // The off bit acts only when the safeguard strap is fitted.
   property p_off;
      reg_wr_in && reg_addr_in == 8'hd1 && reg_wdata_in[2] && osc_safeguard_opt_in
         |-> ##2 !main_osc_en_out;
   endproperty
   a_off: assert property (p_off) else $error("main oscillator not stopped");
   property p_on;
      reg_wr_in && reg_addr_in == 8'hd1 && (!reg_wdata_in[2] || !osc_safeguard_opt_in)
         |-> ##2 main_osc_en_out;
   endproperty
   a_on: assert property (p_on) else $error("main oscillator not enabled");
   property p_gap; int_tick_out && osc_safeguard_opt_in |=> !int_tick_out [*2]; endproperty
   a_gap: assert property (p_gap) else $error("internal clock too fast");
   property p_gap_low;
      int_tick_out && osc_safeguard_opt_in && supply_low_in
         |=> (!int_tick_out || !supply_low_in) [*4];
   endproperty
   a_gap_low: assert property (p_gap_low) else $error("low supply clock too fast");
   property p_por; $rose(int_reset_n_out) |-> int_tick_out; endproperty
   a_por: assert property (p_por) else $error("reset release not after a tick");
   property p_no_aux; !osc_safeguard_opt_in |-> !aux_low_freq_osc_out; endproperty
   a_no_aux: assert property (p_no_aux) else $error("auxiliary without safeguard");
   property p_aux_start; $fell(main_osc_en_out) |-> ##[1:60] aux_low_freq_osc_out; endproperty
   a_aux_start: assert property (p_aux_start) else $error("auxiliary did not start");
   property p_aux_stop;
      aux_low_freq_osc_out && main_running_out && main_osc_en_out |-> ##[0:30] !aux_low_freq_osc_out;
   endproperty
   a_aux_stop: assert property (p_aux_stop) else $error("auxiliary did not stop");
endmodule // csg_chk
bind csg_clock_source_safeguard csg_chk csg_chk_i (.sys_clk_in, .reset_n_in,
   .osc_safeguard_opt_in, .supply_low_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
   .reg_rdata_out, .main_osc_en_out, .aux_low_freq_osc_out, .main_running_out, .int_tick_out,
   .int_reset_n_out);

// *** csg_osc_model.sv ***
// Behavioural crystal or external clock feeding the main oscillator pin.
module csg_osc_model (
   input  wire       clk_in,    // Bench clock that times the waveform.
   input  wire       fitted_in, // High when a clock circuit is fitted.
   input  wire       enable_in, // Main oscillator enable from the block.
   input  wire [3:0] half_in,   // Half period in clock cycles.
   output logic      pin_out    // Waveform on the oscillator pin.
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] cnt_reg = 4'h0; // Cycles spent in the current half period.
   initial pin_out = 1'b0;
   // A stopped crystal holds the pin low, so the block sees missing edges.
   always @(posedge clk_in) begin
      if (!(fitted_in && enable_in)) begin
         cnt_reg <= 4'h0;
         pin_out <= 1'b0;
      end else if (cnt_reg >= half_in - 4'h1) begin
         cnt_reg <= 4'h0;
         pin_out <= ~pin_out;
      end else begin
         cnt_reg <= cnt_reg + 4'h1;
      end
   end
endmodule // csg_osc_model

// *** tb_top.sv ***
// Self-checking bench for the clock source safeguard block.
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int POR = 16; // Shortened reset delay keeps the run brief.
   logic sys_clk_in = 0, reset_n_in = 0, res_opt = 0, sg_opt = 1, supply_low = 0, fitted = 0;
   logic wr = 0, rd = 0, prev_irst = 0;
   logic [3:0] half = 4'h6;
   logic [7:0] addr = 8'h00, wdata = 8'h00, reg_model = 8'h40, lfsr = 8'h3f;
   wire [7:0] rdata;
   wire       pin, osc_en, res_out, aux, running, tick, ptick, ctick, irst_n;
   int n_fail = 0, n_compared = 0, ticks = 0, gap = 0, exp_gap = 0, min_gap = 3;
   always #25 sys_clk_in = ~sys_clk_in;
   csg_clock_source_safeguard #(.AUX_CYC(8), .MISS_CYC(20), .POR_TICKS(POR))
      csg_clock_source_safeguard_i (.sys_clk_in, .reset_n_in, .osc_input_pin_in(pin),
      .resistor_clock_opt_in(res_opt), .osc_safeguard_opt_in(sg_opt), .supply_low_in(supply_low),
      .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
      .reg_rdata_out(rdata), .main_osc_en_out(osc_en), .resistor_clock_out(res_out),
      .aux_low_freq_osc_out(aux), .main_running_out(running), .int_tick_out(tick),
      .periph_tick_out(ptick), .core_tick_out(ctick), .int_reset_n_out(irst_n));
   csg_osc_model csg_osc_model_i (.clk_in(sys_clk_in), .fitted_in(fitted), .enable_in(osc_en),
      .half_in(half), .pin_out(pin));
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   function automatic logic [7:0] lfsr_step(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic tally_and_finish;
      if (n_fail == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // The model counts internal ticks since reset and times the gap between them.
   always @(negedge sys_clk_in) begin
      if (!reset_n_in) begin
         ticks = 0;
         gap = 0;
         prev_irst = 1'b0;
      end else begin
         gap++;
         if (tick === 1'b1) begin
            ticks++;
            if (sg_opt) check("tick gap floor", gap >= min_gap, 1);
            if (exp_gap != 0) check("tick gap", gap, exp_gap);
            gap = 0;
         end
         if (ptick === 1'b1) check("periph tick", ticks % 12, 0);
         if (ctick === 1'b1) check("core tick", ticks % 13, 0);
         if (irst_n === 1'b1 && prev_irst === 1'b0) check("reset release", ticks, POR);
         prev_irst = irst_n;
      end
   end
   // Straps change only while reset is held, as a factory option would.
   task automatic do_reset(input logic sg, input logic res);
      @(posedge sys_clk_in);
      reset_n_in <= 1'b0;
      sg_opt <= sg;
      res_opt <= res;
      exp_gap = 0;
      min_gap = 3;
      repeat (12) @(posedge sys_clk_in);
      reset_n_in <= 1'b1;
      reg_model = 8'h40;
   endtask
   // Optional write, then a read of the same address in the very next cycle.
   task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
      logic [7:0] exp;
      @(posedge sys_clk_in);
      if (w) begin
         addr <= a;
         wdata <= d;
         wr <= 1'b1;
         if (a == 8'hd1) reg_model = d;
         @(posedge sys_clk_in);
         wr <= 1'b0;
      end
      addr <= a;
      rd <= 1'b1;
      @(posedge sys_clk_in);
      rd <= 1'b0;
      exp = (a == 8'hd1) ? reg_model : 8'h00;
      @(negedge sys_clk_in);
      check("reg read", rdata, exp);
   endtask
   // Bounded wait for the internal reset (0) or the auxiliary source (1).
   task automatic wait_hi(input int which, input int lim);
      for (int k = 0; k < lim; k++) begin
         @(negedge sys_clk_in);
         if ((which == 0 ? irst_n : aux) === 1'b1) return;
      end
      check("wait bound", 0, 1);
      tally_and_finish();
   endtask
   initial begin
      do_reset(1'b1, 1'b0); // Safeguard fitted, no crystal.
      wait_hi(0, 600);
      check("aux at power on", aux, 1);
      exp_gap = 8;
      check("resistor strap", res_out, 0);
      access(1'b0, 8'hd1, 8'h00);
      access(1'b1, 8'hd0, 8'hff);
      access(1'b0, 8'hd1, 8'h00);
      for (int i = 0; i < 6; i++) begin
         lfsr = lfsr_step(lfsr);
         access(1'b1, 8'hd1, lfsr & 8'hfb);
         check("enable kept", osc_en, 1);
      end
      exp_gap = 0;
      fitted = 1'b1;
      repeat (60) @(negedge sys_clk_in);
      check("aux dropped", aux, 0);
      exp_gap = 12;
      repeat (100) @(negedge sys_clk_in);
      exp_gap = 0;
      access(1'b1, 8'hd1, 8'h04);
      check("main stopped", osc_en, 0);
      wait_hi(1, 100);
      repeat (30) @(negedge sys_clk_in);
      exp_gap = 8;
      repeat (50) @(negedge sys_clk_in);
      exp_gap = 0;
      access(1'b1, 8'hd1, 8'h00);
      check("main restarted", osc_en, 1);
      repeat (60) @(negedge sys_clk_in);
      check("aux off again", aux, 0);
      half = 4'h2;
      repeat (40) @(negedge sys_clk_in);
      exp_gap = 4;
      repeat (60) @(negedge sys_clk_in);
      exp_gap = 0;
      supply_low = 1'b1;
      repeat (10) @(negedge sys_clk_in);
      min_gap = 5;
      exp_gap = 8;
      repeat (100) @(negedge sys_clk_in);
      supply_low = 1'b0;
      half = 4'h6;
      do_reset(1'b0, 1'b1); // Resistor option, no safeguard.
      wait_hi(0, 600);
      check("resistor strap", res_out, 1);
      access(1'b1, 8'hd1, 8'h04);
      exp_gap = 12;
      repeat (80) @(negedge sys_clk_in);
      check("off bit ignored", osc_en, 1);
      check("no aux", aux, 0);
      tally_and_finish();
   end
endmodule // tb_top
